// ---- hdl/anc_skid_buffer.sv ----
/*
  Two-entry output buffer: a registered output stage plus one skid entry.
  Assumes a synchronous active-high reset; the outputs are flip-flops.
*/
`timescale 1ns/100ps
module anc_skid_buffer
  #(parameter int W = 8)
  (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    anc_stream_if.snk         inPort,
    output logic [W-1:0]      outData,
    output logic              outValid,
    input  wire logic         outReady
  );

  logic [W-1:0] outData_q;
  logic         outValid_q;
  logic [W-1:0] skid_q;
  logic         skidValid_q;
  logic         inFire;

  // ready drops only when the skid entry is taken, so a stall never loses a word
  assign inPort.ready = ~skidValid_q;
  assign inFire       = inPort.valid & ~skidValid_q;
  assign outData      = outData_q;
  assign outValid     = outValid_q;

  // output stage refills from the skid entry first to keep word order
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      outData_q   <= '0;
      outValid_q  <= 1'h0;
      skid_q      <= '0;
      skidValid_q <= 1'h0;
    end
    else if (outReady || !outValid_q)
    begin
      if (skidValid_q)
      begin
        outData_q   <= skid_q;
        outValid_q  <= 1'h1;
        skidValid_q <= 1'h0;
      end
      else
      begin
        outData_q  <= inPort.data;
        outValid_q <= inFire;
      end
    end
    else if (inFire)
    begin
      skid_q      <= inPort.data;
      skidValid_q <= 1'h1;
    end
  end

endmodule // anc_skid_buffer

// ---- hdl/anc_stream_if.sv ----
/*
  Valid/ready word stream between the packet sequencer and its output buffer.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/100ps
interface anc_stream_if
  #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // anc_stream_if

// ---- hdl/vbi_anc_pkg.sv ----
/*
  Constants, types and the parity coding helper of the ancillary packet formatter.
  Assumes one 250 MHz clock and 8-bit type-2 ancillary coding on the output stream.
*/
// Behaviour
// [R01] after end-of-active-video: flag 00 FF FF, DID, SDID, DC, user words, checksum
// [R02] a whole packet never takes more than one hundred bytes of blanking
// [R03] one shared data identifier, six programmable bits, resets to 000001 (41h)
// [R04] identifier bit 6 is even parity of bits 5..0, bit 7 its inverse
// [R05] secondary identifier 41h for wide-screen signalling, 83h for programming system data
// [R06] caption 44h field 2, 85h field 1; guide data 86h field 2, 47h field 1
// [R07] 625 teletext: 48h/89h usual code, 8Ah/4Bh custom code, field 2/field 1
// [R08] 525 teletext: 50h/91h usual code, 92h/53h custom code, field 2/field 1
// [R09] count byte holds number of four-byte groups of user words, six bits
// [R10] count byte bit 6 is even parity of bits 0..5, bit 7 its inverse
// [R11] checksum adds low seven bits of DID, SDID, DC, user words; bit 7 inverts 6
// [R12] each payload byte becomes two words: low nibble first, then high nibble
// [R13] user words leave in the order the payload bytes arrived
// [R14] every packet carries the television line number it was sliced from
// [R15] filler words of 80h keep the user word count a multiple of four
// [R16] the consumer discards filler words and never treats them as payload; anc_sink keeps them in its log with every other byte
// [R17] usual-code teletext: first two words are magazine and page, not split
// [R18] custom-code teletext: first two raw bytes are split like all others
// [R19] teletext payload follows split: 40 bytes to 80 words, 32 to 64
// [R20] magazine and page words: bit 5 zero, parity bit 6, inverse bit 7
// [R21] usual code ends with two fillers; custom code sends 84 or 68 words unpadded
// [R22] every user word has bit 6 even parity of bits 0..5, bit 7 inverse
// [R23] packets go through the output buffer between end and start of video codes
package vbi_anc_pkg;

  typedef enum logic [2:0] {
    FMT_WSS      = 3'b000,
    FMT_VPS      = 3'b001,
    FMT_CAPTION  = 3'b010,
    FMT_GUIDE    = 3'b011,
    FMT_TELETEXT = 3'b100
  } format_type;

  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_WAIT_EAV = 4'b0001,
    S_ADF0     = 4'b0010,
    S_ADF1     = 4'b0011,
    S_ADF2     = 4'b0100,
    S_DID      = 4'b0101,
    S_SDID     = 4'b0110,
    S_DC       = 4'b0111,
    S_TAKE     = 4'b1000,
    S_LO       = 4'b1001,
    S_HI       = 4'b1010,
    S_FILL     = 4'b1011,
    S_CS       = 4'b1100
  } state_type;

  localparam int        LINE_NUM_W      = 10;
  localparam int        BEAT_W          = 8 + 2 + LINE_NUM_W;
  localparam logic [7:0] ADF_FIRST      = 8'h00;
  localparam logic [7:0] ADF_ONES       = 8'hFF;
  localparam logic [5:0] DID_FIELD_RESET = 6'h01;
  localparam logic [7:0] FILL_BYTE      = 8'h80;
  localparam logic [6:0] MAX_PACKET_BYTES = 7'd100;
  localparam logic [6:0] MAX_PAY_BYTES  = 7'd46;
  localparam logic [6:0] HEAD_BYTES     = 7'd2;
  localparam logic [6:0] GROUP_ROUND    = 7'h03;
  localparam logic [6:0] GROUP_MASK     = 7'h7C;
  localparam logic [4:0] MAGAZINE_MASK  = 5'h07;
  localparam logic [4:0] PAGE_MASK      = 5'h1F;
  localparam logic [6:0] POS_DID        = 7'd3;
  localparam logic [6:0] POS_DC         = 7'd5;
  localparam logic [7:0] POS_LAST_BASE  = 8'd6;

  localparam logic [7:0] SDID_WSS       = 8'h41;
  localparam logic [7:0] SDID_VPS       = 8'h83;
  localparam logic [7:0] SDID_CC_F2     = 8'h44;
  localparam logic [7:0] SDID_CC_F1     = 8'h85;
  localparam logic [7:0] SDID_GUIDE_F2  = 8'h86;
  localparam logic [7:0] SDID_GUIDE_F1  = 8'h47;
  localparam logic [7:0] SDID_T625_F2   = 8'h48;
  localparam logic [7:0] SDID_T625_F1   = 8'h89;
  localparam logic [7:0] SDID_T625X_F2  = 8'h8A;
  localparam logic [7:0] SDID_T625X_F1  = 8'h4B;
  localparam logic [7:0] SDID_T525_F2   = 8'h50;
  localparam logic [7:0] SDID_T525_F1   = 8'h91;
  localparam logic [7:0] SDID_T525X_F2  = 8'h92;
  localparam logic [7:0] SDID_T525X_F1  = 8'h53;

  // six data bits plus even parity in bit 6 and its inverse in bit 7
  function automatic logic [7:0] anc_code(input logic [5:0] v);
    anc_code = {~(^v), ^v, v};
  endfunction

endpackage

// ---- hdl/vbi_ancillary_packet_formatter.sv ----
/*
  Ancillary output formatter: turns one line of sliced payload into a type-2
  ancillary packet (flag, identifiers, count, nibble-split words, filler, checksum).
  Assumes the slicer offers a line descriptor, then exactly the announced number
  of payload bytes, or 46 if more are announced, and that eavStrobe is a same-clock pulse at end of active video.
*/
`timescale 1ns/100ps
module vbi_ancillary_packet_formatter
  (
    input  wire logic                             clk_sys,
    input  wire logic                             rst,
    input  wire logic [5:0]                       sharedDataIdField,
    input  wire logic                             lineValid,
    input  vbi_anc_pkg::format_type               lineFormat,
    input  wire logic                             lineField2,
    input  wire logic                             lineStd625,
    input  wire logic                             lineCustom,
    input  wire logic [vbi_anc_pkg::LINE_NUM_W-1:0] lineNumber,
    input  wire logic [6:0]                       lineBytes,
    output logic                                  lineReady,
    input  wire logic                             eavStrobe,
    input  wire logic                             payValid,
    input  wire logic [7:0]                       payData,
    output logic                                  payReady,
    output logic [7:0]                            ancData,
    output logic                                  ancValid,
    output logic                                  ancFirst,
    output logic                                  ancLast,
    output logic [vbi_anc_pkg::LINE_NUM_W-1:0]    ancLine,
    input  wire logic                             ancReady
  );
  import vbi_anc_pkg::*;

  state_type              state_q;
  state_type              state_d;
  format_type             fmt_q;
  logic                   field2_q;
  logic                   std625_q;
  logic                   custom_q;
  logic [LINE_NUM_W-1:0]  line_q;
  logic [5:0]             didField_q;
  logic [6:0]             bytesLeft_q;
  logic [6:0]             byteIdx_q;
  logic [6:0]             padded_q;
  logic [6:0]             wordCnt_q;
  logic [6:0]             csum_q;
  logic [7:0]             pay_q;
  logic                   lineReady_q;
  logic                   payReady_q;

  logic                   lineFire;
  logic                   payFire;
  logic                   wFire;
  logic                   wrValid;
  logic                   isUdw;
  logic                   sumAdd;
  logic                   headNow;
  logic                   inHead;
  logic [6:0]             clampBytes;
  logic [6:0]             headCnt;
  logic [6:0]             udwCnt;
  logic [6:0]             paddedCnt;
  logic [6:0]             wordsAfter;
  logic [7:0]             didByte;
  logic [7:0]             sdidByte;
  logic [7:0]             dcByte;
  logic [7:0]             loWord;
  logic [7:0]             hiWord;
  logic [7:0]             csByte;
  logic [7:0]             curWord;
  state_type              afterWord;
  logic [BEAT_W-1:0]      beat;

  anc_stream_if #(.W(BEAT_W)) coreIf ();

  // secondary identifier from format, field, line standard and frame code kind
  function automatic logic [7:0] sdid_of(input format_type f, input logic f2,
                                         input logic s625, input logic cust);
    logic [7:0] r;
    r = SDID_WSS;
    unique case (f)
      FMT_WSS:      r = SDID_WSS;                                   // R05
      FMT_VPS:      r = SDID_VPS;                                   // R05
      FMT_CAPTION:  r = f2 ? SDID_CC_F2 : SDID_CC_F1;               // R06
      FMT_GUIDE:    r = f2 ? SDID_GUIDE_F2 : SDID_GUIDE_F1;         // R06
      FMT_TELETEXT:
      begin
        if (s625)
          r = cust ? (f2 ? SDID_T625X_F2 : SDID_T625X_F1)
                   : (f2 ? SDID_T625_F2 : SDID_T625_F1);            // R07
        else
          r = cust ? (f2 ? SDID_T525X_F2 : SDID_T525X_F1)
                   : (f2 ? SDID_T525_F2 : SDID_T525_F1);            // R08
      end
      default:      r = SDID_WSS;
    endcase
    sdid_of = r;
  endfunction

  // line descriptor sizing: payload clamped so the packet fits the blanking budget
  assign lineFire   = lineValid & lineReady_q;
  assign headNow    = (lineFormat == FMT_TELETEXT) & ~lineCustom;
  assign clampBytes = (lineBytes > MAX_PAY_BYTES) ? MAX_PAY_BYTES : lineBytes;   // R02
  assign headCnt    = ~headNow ? 7'h00 : ((clampBytes > HEAD_BYTES) ? HEAD_BYTES : clampBytes);
  assign udwCnt     = 7'((clampBytes << 1) - headCnt);                          // R12 R17 R19
  assign paddedCnt  = 7'((udwCnt + GROUP_ROUND) & GROUP_MASK);                   // R15 R21

  // transport bytes; the identifier parity bits are made here, never stored
  assign didByte  = anc_code(didField_q);                                        // R03 R04
  assign sdidByte = sdid_of(fmt_q, field2_q, std625_q, custom_q);
  assign dcByte   = anc_code({1'h0, padded_q[6:2]});                             // R09 R10
  assign csByte   = {~csum_q[6], csum_q};                                        // R11

  // user words: magazine and page go whole, everything else low nibble then high
  assign inHead = (fmt_q == FMT_TELETEXT) & ~custom_q & (byteIdx_q < HEAD_BYTES); // R17 R18
  assign loWord = inHead
                ? anc_code({1'h0, pay_q[4:0] & ((byteIdx_q == 7'h00) ? MAGAZINE_MASK : PAGE_MASK)})
                : anc_code({2'h0, pay_q[3:0]});                                  // R12 R20 R22
  assign hiWord = anc_code({2'h0, pay_q[7:4]});                                  // R12 R22

  // word on offer to the buffer for the current state
  assign curWord = (state_q == S_ADF0) ? ADF_FIRST :
                   (state_q == S_ADF1 || state_q == S_ADF2) ? ADF_ONES :         // R01
                   (state_q == S_DID)  ? didByte  :
                   (state_q == S_SDID) ? sdidByte :
                   (state_q == S_DC)   ? dcByte   :
                   (state_q == S_LO)   ? loWord   :
                   (state_q == S_HI)   ? hiWord   :
                   (state_q == S_FILL) ? FILL_BYTE : csByte;                     // R15

  assign wrValid = (state_q != S_IDLE) & (state_q != S_WAIT_EAV) & (state_q != S_TAKE);
  assign wFire   = wrValid & coreIf.ready;
  assign payFire = payValid & payReady_q;
  assign isUdw   = (state_q == S_LO) | (state_q == S_HI) | (state_q == S_FILL);
  assign sumAdd  = isUdw | (state_q == S_DID) | (state_q == S_SDID) | (state_q == S_DC);
  assign wordsAfter = 7'(wordCnt_q + 7'h01);

  // after a user word: fetch more payload, pad to a group, or close the packet
  assign afterWord = (bytesLeft_q != 7'h00) ? S_TAKE :
                     (wordsAfter < padded_q) ? S_FILL : S_CS;                    // R15 R21

  // the line tag and frame markers travel with every word through the buffer
  assign beat = {state_q == S_ADF0, state_q == S_CS, line_q, curWord};           // R14
  assign coreIf.valid = wrValid;
  assign coreIf.data  = beat;

  // packet sequencer: waits for end of video, then walks the packet layout
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:     if (lineFire) state_d = S_WAIT_EAV;
      S_WAIT_EAV: if (eavStrobe) state_d = S_ADF0;                             // R01
      S_ADF0:     if (wFire) state_d = S_ADF1;
      S_ADF1:     if (wFire) state_d = S_ADF2;
      S_ADF2:     if (wFire) state_d = S_DID;
      S_DID:      if (wFire) state_d = S_SDID;
      S_SDID:     if (wFire) state_d = S_DC;
      S_DC:       if (wFire) state_d = (bytesLeft_q != 7'h00) ? S_TAKE : S_CS;
      S_TAKE:     if (payFire) state_d = S_LO;                                 // R13
      S_LO:       if (wFire) state_d = inHead ? afterWord : S_HI;
      S_HI:       if (wFire) state_d = afterWord;
      S_FILL:     if (wFire) state_d = afterWord;
      S_CS:       if (wFire) state_d = S_IDLE;
      default:    state_d = S_IDLE;
    endcase
  end

  // state and handshake flops; ready is registered so the pins come from flops
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q     <= S_IDLE;
      lineReady_q <= 1'h0;
      payReady_q  <= 1'h0;
    end
    else
    begin
      state_q     <= state_d;
      lineReady_q <= (state_d == S_IDLE);
      payReady_q  <= (state_d == S_TAKE);
    end
  end

  // line context, latched once per packet so a new descriptor cannot tear it
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fmt_q      <= FMT_WSS;
      field2_q   <= 1'h0;
      std625_q   <= 1'h0;
      custom_q   <= 1'h0;
      line_q     <= '0;
      didField_q <= DID_FIELD_RESET;                                             // R03
      padded_q   <= 7'h00;
    end
    else if (lineFire)
    begin
      fmt_q      <= lineFormat;
      field2_q   <= lineField2;
      std625_q   <= lineStd625;
      custom_q   <= lineCustom;
      line_q     <= lineNumber;                                                  // R14
      didField_q <= sharedDataIdField;
      padded_q   <= paddedCnt;
    end
  end

  // payload counters and the held byte; one byte in flight keeps arrival order
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bytesLeft_q <= 7'h00;
      byteIdx_q   <= 7'h00;
      pay_q       <= 8'h00;
    end
    else if (lineFire)
    begin
      bytesLeft_q <= clampBytes;
      byteIdx_q   <= 7'h00;
    end
    else
    begin
      if (payFire)
      begin
        pay_q       <= payData;                                                  // R13
        bytesLeft_q <= 7'(bytesLeft_q - 7'h01);
      end
      if (wFire && ((state_q == S_LO && inHead) || state_q == S_HI))
        byteIdx_q <= 7'(byteIdx_q + 7'h01);
    end
  end

  // word count and running checksum; carries past bit 6 simply fall away
  always_ff @(posedge clk_sys)
  begin
    if (rst || lineFire)
    begin
      wordCnt_q <= 7'h00;
      csum_q    <= 7'h00;
    end
    else if (wFire)
    begin
      if (isUdw)
        wordCnt_q <= wordsAfter;
      if (sumAdd)
        csum_q <= 7'(csum_q + curWord[6:0]);                                     // R11
    end
  end

  anc_skid_buffer #(.W(BEAT_W)) u_outBuffer
  (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inPort   (coreIf.snk),
    .outData  ({ancFirst, ancLast, ancLine, ancData}),
    .outValid (ancValid),
    .outReady (ancReady)
  );                                                                             // R23

  assign lineReady = lineReady_q;
  assign payReady  = payReady_q;

  // checking helpers: position in packet, observed sum, count and line tag
  logic                  outFire;
  logic [6:0]            outIdx_q;
  logic [6:0]            sumChk_q;
  logic [5:0]            dcChk_q;
  logic [LINE_NUM_W-1:0] lineChk_q;

  assign outFire = ancValid & ancReady;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      outIdx_q  <= 7'h00;
      sumChk_q  <= 7'h00;
      dcChk_q   <= 6'h00;
      lineChk_q <= '0;
    end
    else if (outFire)
    begin
      outIdx_q <= ancLast ? 7'h00 : 7'(outIdx_q + 7'h01);
      if (outIdx_q == 7'h00)
        lineChk_q <= ancLine;
      if (outIdx_q == POS_DC)
        dcChk_q <= ancData[5:0];
      if (ancLast)
        sumChk_q <= 7'h00;
      else if (outIdx_q >= POS_DID)
        sumChk_q <= 7'(sumChk_q + ancData[6:0]);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_adf_lead;
    outFire && outIdx_q == 7'h00 |-> ancFirst && ancData == ADF_FIRST;
  endproperty
  a_adf_lead: assert property (p_adf_lead) else $error("packet does not open with 00h"); // R01

  property p_adf_ones;
    outFire && (outIdx_q == 7'h01 || outIdx_q == 7'h02) |-> ancData == ADF_ONES && !ancFirst;
  endproperty
  a_adf_ones: assert property (p_adf_ones) else $error("flag bytes two and three not FFh"); // R01

  property p_eav_start;
    state_q == S_WAIT_EAV && eavStrobe |=> state_q == S_ADF0 ##1 coreIf.valid;
  endproperty
  a_eav_start: assert property (p_eav_start) else $error("packet start missed"); // R01

  property p_length;
    outFire |-> outIdx_q < MAX_PACKET_BYTES;
  endproperty
  a_length: assert property (p_length) else $error("packet longer than one hundred bytes"); // R02

  property p_did_parity;
    outFire && outIdx_q == POS_DID |-> ancData == anc_code(ancData[5:0]);
  endproperty
  a_did_parity: assert property (p_did_parity) else $error("identifier parity wrong"); // R04

  property p_word_parity;
    outFire && outIdx_q > POS_DID && !ancLast
      |-> ancData[6] == ^ancData[5:0] && ancData[7] != ancData[6];
  endproperty
  a_word_parity: assert property (p_word_parity) else $error("word parity bits wrong"); // R22

  property p_group_count;
    outFire && ancLast |-> {1'h0, outIdx_q} == 8'(POS_LAST_BASE + {dcChk_q, 2'h0});
  endproperty
  a_group_count: assert property (p_group_count) else $error("count byte mismatch"); // R09

  property p_checksum;
    outFire && ancLast |-> ancData == {~sumChk_q[6], sumChk_q};
  endproperty
  a_checksum: assert property (p_checksum) else $error("checksum byte wrong"); // R11

  property p_line_tag;
    ancValid && outIdx_q != 7'h00 |-> ancLine == lineChk_q;
  endproperty
  a_line_tag: assert property (p_line_tag) else $error("line tag changed inside a packet"); // R14

  property p_take_order;
    payFire |=> state_q == S_LO && !payReady_q;
  endproperty
  a_take_order: assert property (p_take_order) else $error("payload byte not held"); // R13

  c_packet:   cover property (outFire && ancLast);
  c_stall:    cover property (ancValid && !ancReady ##1 ancValid && !ancReady);
  c_fill:     cover property (wFire && state_q == S_FILL);
  c_teletext: cover property (lineFire && lineFormat == FMT_TELETEXT && !lineCustom);

endmodule // vbi_ancillary_packet_formatter

// ---- verification/anc_sink.sv ----
/*
  Downstream consumer of the ancillary byte stream: logs every accepted byte.
  Assumes the formatter's clock and reset; slow=1 stalls five of every eight cycles.
*/
`timescale 1ns/100ps
module anc_sink
  (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] ancData,
    input  wire logic       ancValid,
    input  wire logic       ancFirst,
    input  wire logic       ancLast,
    input  wire logic [9:0] ancLine,
    input  wire logic       slow,
    output logic            ancReady
  );
  logic [7:0] got[$];
  logic       fst;
  logic [9:0] lineSeen;
  int         nDone = 0;
  logic [2:0] cyc = 3'h0;

  initial ancReady = 1'b0;

  // pad words stay in the raw log; a payload reader stops at the announced count
  always @(posedge clk_sys)
  begin
    if (ancValid && ancReady)
    begin
      if (got.size() == 0)
      begin
        fst = ancFirst;
        lineSeen = ancLine;
      end
      got.push_back(ancData);
      if (ancLast)
        nDone++;
    end
    cyc <= cyc + 3'h1;
    // long stalls fill the two-entry buffer so the sequencer must halt
    ancReady <= #1 !rst && (!slow || cyc > 3'h4);
  end
endmodule // anc_sink

// ---- verification/tb_vbi_ancillary_packet_formatter.sv ----
/*
  Self-checking bench of the ancillary packet formatter: one row per secondary identifier, plus a clamp row.
  Assumes anc_sink as the consumer and a 250 MHz clock.
*/
`timescale 1ns/100ps
module tb_vbi_ancillary_packet_formatter;
  import vbi_anc_pkg::*;
  typedef struct {format_type f; logic f2; logic s6; logic cu;
                  logic [6:0] n; logic [5:0] did; logic [7:0] sd;} row_type;
  logic       clk_sys, rst, lineValid, lineField2, lineStd625, lineCustom;
  logic       lineReady, eavStrobe, payValid, payReady, ancValid;
  logic       ancFirst, ancLast, ancReady, slow;
  logic [5:0] sharedDataIdField;
  format_type lineFormat;
  logic [6:0] lineBytes;
  logic [7:0] payData, ancData;
  logic [9:0] lineNumber, ancLine;
  int         miscompares = 0;
  int         checks = 0;
  int         i;
  // every secondary identifier once; last row asks for more than the clamp
  row_type rows[15] = '{
    '{FMT_WSS, 0, 0, 0, 7'h04, 6'h01, 8'h41}, '{FMT_VPS, 0, 0, 0, 7'h06, 6'h3F, 8'h83},
    '{FMT_CAPTION, 1, 0, 0, 7'h02, 6'h15, 8'h44}, '{FMT_CAPTION, 0, 0, 0, 7'h02, 6'h2A, 8'h85},
    '{FMT_GUIDE, 1, 0, 0, 7'h03, 6'h01, 8'h86}, '{FMT_GUIDE, 0, 0, 0, 7'h03, 6'h07, 8'h47},
    '{FMT_TELETEXT, 1, 1, 0, 7'h2A, 6'h01, 8'h48}, '{FMT_TELETEXT, 0, 1, 0, 7'h2A, 6'h01, 8'h89},
    '{FMT_TELETEXT, 1, 1, 1, 7'h2A, 6'h01, 8'h8A}, '{FMT_TELETEXT, 0, 1, 1, 7'h2A, 6'h01, 8'h4B},
    '{FMT_TELETEXT, 1, 0, 0, 7'h22, 6'h01, 8'h50}, '{FMT_TELETEXT, 0, 0, 0, 7'h22, 6'h01, 8'h91},
    '{FMT_TELETEXT, 1, 0, 1, 7'h22, 6'h01, 8'h92}, '{FMT_TELETEXT, 0, 0, 1, 7'h22, 6'h01, 8'h53},
    '{FMT_WSS, 0, 0, 0, 7'h7F, 6'h01, 8'h41}};

  vbi_ancillary_packet_formatter u_dut (.clk_sys(clk_sys), .rst(rst),
    .sharedDataIdField(sharedDataIdField), .lineValid(lineValid), .lineFormat(lineFormat),
    .lineField2(lineField2), .lineStd625(lineStd625), .lineCustom(lineCustom),
    .lineNumber(lineNumber), .lineBytes(lineBytes), .lineReady(lineReady),
    .eavStrobe(eavStrobe), .payValid(payValid), .payData(payData), .payReady(payReady),
    .ancData(ancData), .ancValid(ancValid), .ancFirst(ancFirst), .ancLast(ancLast),
    .ancLine(ancLine), .ancReady(ancReady));

  anc_sink u_sink (.clk_sys(clk_sys), .rst(rst), .ancData(ancData), .ancValid(ancValid),
    .ancFirst(ancFirst), .ancLast(ancLast), .ancLine(ancLine), .slow(slow),
    .ancReady(ancReady));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // six bits plus even parity and its inverse, built here independently
  function automatic logic [7:0] cw(input logic [5:0] v);
    return {~(^v), ^v, v};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hold the request until ready is seen at a rising edge; w selects payload side
  task automatic take(input int w);
    int k;
    for (k = 0; (w ? payReady : lineReady) !== 1'b1 && k < 2000; k++)
      @(negedge clk_sys);
    if (k == 2000)
    begin
      miscompares++;
      end_of_test;
    end
    else
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  task automatic runPkt(input row_type r, input logic [9:0] ln);
    logic [7:0] e[$];
    logic [7:0] b[46];
    logic [7:0] s;
    int         nb, k, d0;
    nb = (r.n > 7'd46) ? 46 : int'(r.n);
    e = {8'h00, 8'hFF, 8'hFF, cw(r.did), r.sd, 8'h00};
    for (k = 0; k < nb; k++)
    begin
      b[k] = 8'(k * 37 + int'(ln));
      if (r.f == FMT_TELETEXT && !r.cu && k < 2)
        e.push_back(cw(k == 0 ? {3'b000, b[k][2:0]} : {1'b0, b[k][4:0]}));
      else
      begin
        e.push_back(cw({2'b00, b[k][3:0]}));
        e.push_back(cw({2'b00, b[k][7:4]}));
      end
    end
    while ((e.size() - 6) % 4 != 0)
      e.push_back(8'h80);
    e[5] = cw(6'((e.size() - 6) / 4));
    s = 8'h00;
    for (k = 3; k < e.size(); k++)
      s = s + {1'b0, e[k][6:0]};
    e.push_back({~s[6], s[6:0]});
    u_sink.got.delete();
    d0 = u_sink.nDone;
    // descriptor changes a fixed delay after the rising edge, like every other input
    @(posedge clk_sys);
    #1 lineFormat = r.f;
    {lineField2, lineStd625, lineCustom} = {r.f2, r.s6, r.cu};
    {lineBytes, sharedDataIdField, lineNumber, lineValid} = {r.n, r.did, ln, 1'b1};
    take(0);
    lineValid = 1'b0;
    eavStrobe = 1'b1;
    @(posedge clk_sys);
    #1 eavStrobe = 1'b0;
    payValid = 1'b1;
    for (k = 0; k < nb; k++)
    begin
      payData = b[k];
      take(1);
    end
    payValid = 1'b0;
    for (k = 0; u_sink.nDone == d0 && k < 3000; k++)
      @(negedge clk_sys);
    if (k == 3000)
    begin
      miscompares++;
      end_of_test;
    end
    else
    begin
      chk(16'(u_sink.got.size()), 16'(e.size()));
      for (k = 0; k < e.size() && k < u_sink.got.size(); k++)
        chk(u_sink.got[k], e[k]);
      chk(u_sink.fst, 1'b1);
      chk(u_sink.lineSeen, ln);
    end
  endtask

  initial
  begin
    {rst, lineValid, eavStrobe, payValid, slow} = 5'b10000;
    {lineField2, lineStd625, lineCustom, payData} = 11'h000;
    {sharedDataIdField, lineBytes, lineNumber} = 23'h0;
    lineFormat = FMT_WSS;
    repeat (16) @(posedge clk_sys);
    #1 chk({ancValid, lineReady, payReady}, 3'b000);
    rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk(lineReady, 1'b1);
    // alternate rows run against a stalling consumer
    for (i = 0; i < 15; i++)
    begin
      slow = i[0];
      runPkt(rows[i], 10'(i * 23 + 6));
    end
    // reset while a packet waits for payload; the next packet must still come out whole
    @(posedge clk_sys);
    #1 lineValid = 1'b1;
    take(0);
    lineValid = 1'b0;
    eavStrobe = 1'b1;
    @(posedge clk_sys);
    #1 eavStrobe = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({ancValid, lineReady, payReady}, 3'b000);
    rst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(lineReady, 1'b1);
    runPkt(rows[1], 10'h3FF);
    end_of_test;
  end
endmodule // tb_vbi_ancillary_packet_formatter
